// ---- logic/bmio_pkg.sv ----
package bmio_pkg;

   // ==========================================================
   // register map (byte addresses on the AHB-Lite slave)
   // ==========================================================
   localparam logic [7:0] LOW_DATA_OFS   = 8'h00;
   localparam logic [7:0] LOW_DIR_OFS    = 8'h04;
   localparam logic [7:0] HIGH_DATA_OFS  = 8'h08;
   localparam logic [7:0] HIGH_DIR_OFS   = 8'h0C;
   localparam logic [7:0] CTRL_DATA_OFS  = 8'h10;
   localparam logic [7:0] CTRL_DIR_OFS   = 8'h14;
   localparam logic [7:0] MODE_OFS       = 8'h18;
   localparam logic [7:0] BUS_CMD_OFS    = 8'h1C;
   localparam logic [7:0] BUS_ADDR_OFS   = 8'h20;
   localparam logic [7:0] BUS_STAT_OFS   = 8'h24;

   // ==========================================================
   // reset values and field positions
   // ==========================================================
   localparam logic [7:0]  DATA_RST      = 8'h00;
   localparam logic [7:0]  DIR_RST       = 8'hFF;
   localparam logic [2:0]  CTRL_DIR_RST  = 3'h7;
   localparam logic [1:0]  MODE_RST      = 2'h0;
   localparam int          CMD_WR_BIT    = 0;
   localparam int          CMD_GO_BIT    = 1;
   localparam int          STAT_BUSY_BIT = 0;
   localparam int          CTRL_ALE_BIT  = 0;
   localparam int          CTRL_OE_BIT   = 1;
   localparam int          CTRL_WR_BIT   = 2;

   // ==========================================================
   // timing: each bus phase after the address phase lasts one enable tick period of PHASE_DIV clocks
   // ==========================================================
   localparam int          PHASE_DIV     = 4;

   // program memory modes
   typedef enum logic [1:0] {
      BMIO_MODE_INT       = 2'b00,
      BMIO_MODE_INT_PROT  = 2'b01,
      BMIO_MODE_EXT_MIXED = 2'b10,
      BMIO_MODE_EXT_ONLY  = 2'b11
   } bmio_mode_e;

   typedef enum logic [2:0] {
      BMIO_ST_IDLE  = 3'b000,
      BMIO_ST_ADDR  = 3'b001,
      BMIO_ST_LATCH = 3'b010,
      BMIO_ST_DATA  = 3'b011,
      BMIO_ST_DONE  = 3'b100
   } bmio_state_e;

   // pin group carrier
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } bmio_pins_s;

   typedef struct packed {
      logic [2:0] o;
      logic [2:0] oe;
   } bmio_ctrl_s;

endpackage : bmio_pkg

// ---- logic/bmio_pin_mux.sv ----
`timescale 1ns/1ns
module bmio_pin_mux #(
   parameter int WIDTH = 8
) (
   input  wire logic             bus_active,
   input  wire logic [WIDTH-1:0] latch_val,
   input  wire logic [WIDTH-1:0] dir_val,
   input  wire logic [WIDTH-1:0] bus_o,
   input  wire logic [WIDTH-1:0] bus_oe,
   output      logic [WIDTH-1:0] pin_o,
   output      logic [WIDTH-1:0] pin_oe
);
   // refused at elaboration: a zero-width group has no pins
   if (WIDTH < 1) begin : g_bad_width
      $error("bmio_pin_mux: WIDTH must be at least 1");
   end

   always_comb begin
      if (bus_active) begin
         pin_o  = bus_o;
         pin_oe = bus_oe;
      end else begin
         pin_o  = latch_val;
         pin_oe = ~dir_val;
      end
   end
endmodule : bmio_pin_mux

// ---- logic/bmio_phase_div.sv ----
`timescale 1ns/1ns
module bmio_phase_div #(
   parameter int DIV = 4
) (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   output      logic tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] cnt_r;

   // refused at elaboration: a zero divide never ticks
   if (DIV < 1) begin : g_bad_div
      $error("bmio_phase_div: DIV must be at least 1");
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (cnt_r == LAST);
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule : bmio_phase_div

// ---- logic/bmio_top.sv ----
`timescale 1ns/1ns
// Functional notes
// - two 8-pin ports, per-pin data/direction
// - direction one input, zero drives latch
// - data read pins, write latch only
// - low port carries address/data 7:0
// - high port carries address/data 15:8
// - external modes select bus use
// - control bit 0 is address latch
// - control bit 1 is output enable
// - control bit 2 is write strobe
module bmio_top (
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   // ahb-lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output      logic [31:0]          hrdata,
   output      logic                 hreadyout,
   output      logic                 hresp,
   // pins
   input  wire logic [7:0]           low_bus_port_in,
   output      bmio_pkg::bmio_pins_s low_bus_port_pins,
   input  wire logic [7:0]           high_bus_port_in,
   output      bmio_pkg::bmio_pins_s high_bus_port_pins,
   input  wire logic [2:0]           ctrl_port_in,
   output      bmio_pkg::bmio_ctrl_s ctrl_port_pins
);
   import bmio_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   logic [7:0]  low_bus_port_data_r;
   logic [7:0]  low_bus_port_direction_r;
   logic [7:0]  high_bus_port_data_r;
   logic [7:0]  high_bus_port_direction_r;
   logic [2:0]  ctrl_port_data_r;
   logic [2:0]  ctrl_port_direction_r;
   bmio_mode_e  mode_r;
   logic [15:0] bus_addr_r;
   logic        bus_wr_r;
   logic [15:0] bus_rdata_r;
   bmio_state_e st_r;
   logic        bus_active;
   logic        tick;
   logic        dp_valid_r;
   logic        dp_write_r;
   logic [7:0]  dp_addr_r;
   logic [31:0] rdata_nxt;
   logic        addr_ph;
   logic        wr_en;
   logic [15:0] bus_o;
   logic [15:0] bus_oe;
   logic [2:0]  strobe_o;
   logic [7:0]  low_o;
   logic [7:0]  low_oe;
   logic [7:0]  high_o;
   logic [7:0]  high_oe;
   logic [2:0]  ctrl_o;
   logic [2:0]  ctrl_oe;

   assign bus_active = (mode_r == BMIO_MODE_EXT_MIXED) || (mode_r == BMIO_MODE_EXT_ONLY);

   // ==========================================================
   // ahb-lite address phase capture
   // ==========================================================
   assign addr_ph = hsel && hready && htrans[1];
   assign wr_en   = dp_valid_r && dp_write_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r  <= 8'h00;
      end else if (hready) begin
         dp_valid_r <= addr_ph;
         dp_write_r <= hwrite;
         dp_addr_r  <= haddr[7:0];
      end
   end

   // ==========================================================
   // ahb-lite response
   // ==========================================================
   // zero-wait slave, always okay
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ==========================================================
   // port registers
   // ==========================================================
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         low_bus_port_data_r       <= DATA_RST;
         low_bus_port_direction_r  <= DIR_RST;
         high_bus_port_data_r      <= DATA_RST;
         high_bus_port_direction_r <= DIR_RST;
         ctrl_port_data_r          <= DATA_RST[2:0];
         ctrl_port_direction_r     <= CTRL_DIR_RST;
      end else if (wr_en) begin
         unique case (dp_addr_r)
            LOW_DATA_OFS:  low_bus_port_data_r       <= hwdata[7:0];
            LOW_DIR_OFS:   low_bus_port_direction_r  <= hwdata[7:0];
            HIGH_DATA_OFS: high_bus_port_data_r      <= hwdata[7:0];
            HIGH_DIR_OFS:  high_bus_port_direction_r <= hwdata[7:0];
            CTRL_DATA_OFS: ctrl_port_data_r          <= hwdata[2:0];
            CTRL_DIR_OFS:  ctrl_port_direction_r     <= hwdata[2:0];
            // unmapped offsets: write ignored
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_r     <= BMIO_MODE_INT;
         bus_addr_r <= 16'h0000;
      end else if (wr_en) begin
         if (dp_addr_r == MODE_OFS) begin
            mode_r <= bmio_mode_e'(hwdata[1:0]);
         end
         if (dp_addr_r == BUS_ADDR_OFS) begin
            bus_addr_r <= hwdata[15:0];
         end
      end
   end

   // ==========================================================
   // read mux
   // ==========================================================
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (haddr[7:0])
         LOW_DATA_OFS:  rdata_nxt[7:0] = low_bus_port_in;
         LOW_DIR_OFS:   rdata_nxt[7:0] = low_bus_port_direction_r;
         HIGH_DATA_OFS: rdata_nxt[7:0] = high_bus_port_in;
         HIGH_DIR_OFS:  rdata_nxt[7:0] = high_bus_port_direction_r;
         CTRL_DATA_OFS: rdata_nxt[2:0] = ctrl_port_in;
         CTRL_DIR_OFS:  rdata_nxt[2:0] = ctrl_port_direction_r;
         MODE_OFS:      rdata_nxt[1:0] = mode_r;
         BUS_ADDR_OFS:  rdata_nxt[15:0] = bus_addr_r;
         BUS_STAT_OFS: begin
            rdata_nxt[STAT_BUSY_BIT] = (st_r != BMIO_ST_IDLE);
            rdata_nxt[31:16]         = bus_rdata_r;
         end
         default:       rdata_nxt = 32'h0000_0000;
      endcase
   end

   // limitation: a read right behind a write sees the old value
   // registered so hrdata is a flop; sampled at address phase
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ph && !hwrite) begin
         hrdata <= rdata_nxt;
      end
   end

   // ==========================================================
   // bus sequencer: address, latch, data, done
   // ==========================================================
   // free-running divider: the address phase may run short
   bmio_phase_div #(
      .DIV (PHASE_DIV)
   ) u_div (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .tick    (tick)
   );

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r     <= BMIO_ST_IDLE;
         bus_wr_r <= 1'b0;
      end else if (st_r == BMIO_ST_IDLE) begin
         // a cycle is started only while the bus owns the pins
         if (wr_en && dp_addr_r == BUS_CMD_OFS && hwdata[CMD_GO_BIT] && bus_active) begin
            st_r     <= BMIO_ST_ADDR;
            bus_wr_r <= hwdata[CMD_WR_BIT];
         end
      end else if (!bus_active) begin
         // leaving bus mode drops the cycle at once
         st_r <= BMIO_ST_IDLE;
      end else if (tick) begin
         unique case (st_r)
            BMIO_ST_ADDR:  st_r <= BMIO_ST_LATCH;
            BMIO_ST_LATCH: st_r <= BMIO_ST_DATA;
            BMIO_ST_DATA:  st_r <= BMIO_ST_DONE;
            BMIO_ST_DONE:  st_r <= BMIO_ST_IDLE;
            default:       st_r <= BMIO_ST_IDLE;
         endcase
      end
   end

   // read data captured at the end of the data phase
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata_r <= 16'h0000;
      end else if (tick && st_r == BMIO_ST_DATA && !bus_wr_r) begin
         bus_rdata_r <= {high_bus_port_in, low_bus_port_in};
      end
   end

   // idle bus keeps the address driven so no pin floats
   always_comb begin
      bus_o  = (st_r == BMIO_ST_DATA) ? hwdata_hold() : bus_addr_r;
      bus_oe = 16'hFFFF;
      if ((st_r == BMIO_ST_DATA || st_r == BMIO_ST_DONE) && !bus_wr_r) begin
         bus_oe = 16'h0000;
      end
   end

   always_comb begin
      strobe_o = 3'h0;
      strobe_o[CTRL_ALE_BIT] = (st_r == BMIO_ST_ADDR);
      // output enable active low on read
      strobe_o[CTRL_OE_BIT]  = !(st_r == BMIO_ST_DATA && !bus_wr_r);
      // write strobe active low on write
      strobe_o[CTRL_WR_BIT]  = !(st_r == BMIO_ST_DATA && bus_wr_r);
   end

   // write data reuses the address register's companion: bus_rdata_r
   function automatic logic [15:0] hwdata_hold();
      return bus_wr_r ? bus_rdata_r : bus_addr_r;
   endfunction : hwdata_hold

   // ==========================================================
   // pin muxes
   // ==========================================================
   bmio_pin_mux #(
      .WIDTH (8)
   ) u_low (
      .bus_active (bus_active),
      .latch_val  (low_bus_port_data_r),
      .dir_val    (low_bus_port_direction_r),
      .bus_o      (bus_o[7:0]),
      .bus_oe     (bus_oe[7:0]),
      .pin_o      (low_o),
      .pin_oe     (low_oe)
   );

   bmio_pin_mux #(
      .WIDTH (8)
   ) u_high (
      .bus_active (bus_active),
      .latch_val  (high_bus_port_data_r),
      .dir_val    (high_bus_port_direction_r),
      .bus_o      (bus_o[15:8]),
      .bus_oe     (bus_oe[15:8]),
      .pin_o      (high_o),
      .pin_oe     (high_oe)
   );

   bmio_pin_mux #(
      .WIDTH (3)
   ) u_ctrl (
      .bus_active (bus_active),
      .latch_val  (ctrl_port_data_r),
      .dir_val    (ctrl_port_direction_r),
      .bus_o      (strobe_o),
      .bus_oe     (3'h7),
      .pin_o      (ctrl_o),
      .pin_oe     (ctrl_oe)
   );

   // ==========================================================
   // output registers
   // ==========================================================
   // outputs straight from flops: pins lag their registers a clock
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         low_bus_port_pins  <= '0;
         high_bus_port_pins <= '0;
         ctrl_port_pins     <= '0;
      end else begin
         low_bus_port_pins  <= '{o: low_o, oe: low_oe};
         high_bus_port_pins <= '{o: high_o, oe: high_oe};
         ctrl_port_pins     <= '{o: ctrl_o, oe: ctrl_oe};
      end
   end

endmodule : bmio_top

// ---- tb/bmio_ext_mem.sv ----
`timescale 1ns/1ns
module bmio_ext_mem (
   input  wire logic        clk_sys,
   input  wire logic [15:0] ad,
   input  wire logic [2:0]  strobes,
   output      logic        drive_en,
   output      logic [15:0] drive_val,
   output      logic [15:0] last_addr
);
   logic [15:0] mem [16];
   initial begin
      last_addr = 16'h0000;
      for (int i = 0; i < 16; i++) mem[i] = {4'(i), 12'h5C3};
   end
   assign drive_en  = ~strobes[1];
   assign drive_val = mem[last_addr[3:0]];
   always @(posedge clk_sys) begin
      if (strobes[0]) last_addr <= ad;
      if (!strobes[2]) mem[last_addr[3:0]] <= ad;
   end
endmodule : bmio_ext_mem

// ---- tb/bmio_top_monitor.sv ----
`timescale 1ns/1ns
module bmio_top_monitor (
   input wire logic                 clk_sys,
   input wire logic                 arst_n,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire bmio_pkg::bmio_pins_s low_bus_port_pins,
   input wire bmio_pkg::bmio_pins_s high_bus_port_pins,
   input wire bmio_pkg::bmio_ctrl_s ctrl_port_pins
);
   import bmio_pkg::*;
   logic ale, rd_stb, wr_stb, addr_out, addr_off;
   assign ale      = ctrl_port_pins.o[0] & ctrl_port_pins.oe[0];
   assign rd_stb   = ctrl_port_pins.oe[1] & ~ctrl_port_pins.o[1];
   assign wr_stb   = ctrl_port_pins.oe[2] & ~ctrl_port_pins.o[2];
   assign addr_out = (&low_bus_port_pins.oe) & (&high_bus_port_pins.oe);
   assign addr_off = ~(|low_bus_port_pins.oe) & ~(|high_bus_port_pins.oe);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // bus cycle phases
   // ==========================================================
   sequence s_quiet_latch;
      !(rd_stb || wr_stb) [*4];
   endsequence
   sequence s_data_phase;
      (rd_stb || wr_stb) [*4] ##1 !(rd_stb || wr_stb);
   endsequence
   a_ready_high: assert property (hreadyout) else $error("ready dropped");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_addr_driven: assert property (ale |-> addr_out) else $error("address not driven");
   a_ctrl_owned: assert property (ale |-> ctrl_port_pins.oe == 3'h7)
      else $error("strobes not owned");
   a_read_release: assert property (rd_stb |-> addr_off) else $error("bus not released");
   a_write_drive: assert property (wr_stb |-> addr_out) else $error("write data off");
   a_strobe_excl: assert property (!(ale && (rd_stb || wr_stb)) && !(rd_stb && wr_stb))
      else $error("strobes overlap");
   a_latch_gap: assert property ($fell(ale) |-> s_quiet_latch ##1 s_data_phase)
      else $error("phase length wrong");
endmodule : bmio_top_monitor

// ---- tb/tb_bmio_top.sv ----
`timescale 1ns/1ns
module tb_bmio_top;
   import bmio_pkg::*;
   logic        clk_sys, arst_n, hsel, hwrite, hready, hresp, hreadyout, pe;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, cw;
   logic [15:0] ext, ad, pv, la;
   bmio_pins_s  lp, hp, pin;
   bmio_ctrl_s  cp;
   int          miscompares = 0, comparisons = 0, cycles = 0;
   logic [7:0]  ofs [5] = '{LOW_DIR_OFS, HIGH_DIR_OFS, CTRL_DIR_OFS, MODE_OFS, 8'h30};
   logic [31:0] rst [5] = '{32'hFF, 32'hFF, 32'h7, 32'h0, 32'h0};
   // undriven strobes rest inactive, undriven data shows the memory while it drives, else the bench pattern
   assign ad = ({hp.o, lp.o} & {hp.oe, lp.oe}) | (~{hp.oe, lp.oe} & (pe ? pv : ext));
   assign cw = (cp.o & cp.oe) | (~cp.oe & 3'h6);
   assign hready = hreadyout;
   bmio_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .low_bus_port_in(ad[7:0]),
      .low_bus_port_pins(lp), .high_bus_port_in(ad[15:8]), .high_bus_port_pins(hp),
      .ctrl_port_in(cw), .ctrl_port_pins(cp));
   bmio_ext_mem i_mem (.clk_sys(clk_sys), .ad(ad), .strobes(cw), .drive_en(pe),
      .drive_val(pv), .last_addr(la));
   // ==========================================================
   // bus tasks
   // ==========================================================
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic bus_op(input logic [15:0] a, input logic w);
      xfer(BUS_ADDR_OFS, 1'b1, {16'h0, a});
      xfer(BUS_CMD_OFS, 1'b1, {30'h0, 1'b1, w});
      rd = 32'h1;
      for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) xfer(BUS_STAT_OFS, 1'b0, 32'h0);
      check("bus done", {31'h0, rd[0]}, 32'h0);
   endtask : bus_op
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic results();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // a full run needs a few hundred cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      {hwrite, htrans, haddr, hwdata} = '0;
      hsel   = 1'b1;
      hsize  = 3'h2;
      ext    = 16'h3C3C;
      arst_n = 1'b0;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      // one flat bank: direction and mode registers keep their reset values after an unmapped write
      xfer(8'h30, 1'b1, 32'hFFFFFFFF);
      for (int i = 0; i < 5; i++) begin
         xfer(ofs[i], 1'b0, 32'h0);
         check("reset value", rd, rst[i]);
      end
      for (int p = 0; p < 2; p++) begin
         logic [7:0] b;
         b = p ? HIGH_DATA_OFS : LOW_DATA_OFS;
         xfer(b, 1'b1, 32'hA5);
         xfer(b + 8'h04, 1'b1, 32'h0F);
         xfer(b, 1'b1, 32'h5A);
         repeat (2) @(posedge clk_sys);
         pin = p ? hp : lp;
         check("pin enable", {24'h0, pin.oe}, 32'hF0);
         check("pin latch", {24'h0, pin.o}, 32'h5A);
         xfer(b, 1'b0, 32'h0);
         check("pin read", rd, 32'h5C);
         xfer(b + 8'h04, 1'b1, 32'hFF);
      end
      xfer(CTRL_DATA_OFS, 1'b1, 32'h6);
      xfer(CTRL_DIR_OFS, 1'b1, 32'h0);
      repeat (2) @(posedge clk_sys);
      check("ctrl drive", {26'h0, cp.oe, cp.o}, 32'h3E);
      xfer(CTRL_DATA_OFS, 1'b0, 32'h0);
      check("ctrl read", rd, 32'h6);
      xfer(CTRL_DIR_OFS, 1'b1, 32'h7);
      for (int m = 0; m < 4; m++) begin
         xfer(MODE_OFS, 1'b1, 32'(m));
         bus_op(16'h3500 + 16'(m), 1'b0);
         check("bus address", {16'h0, la}, m > 1 ? 32'h3500 + m : 32'h0);
         check("bus read", {16'h0, rd[31:16]}, m > 1 ? {16'h0, 4'(m), 12'h5C3} : 32'h0);
         if (m > 1) begin
            bus_op(16'h4A05 + 16'(m), 1'b1);
            bus_op(16'h4A05 + 16'(m), 1'b0);
            check("bus write", {16'h0, rd[31:16]}, {16'h0, 4'(m), 12'h5C3});
         end
      end
      xfer(MODE_OFS, 1'b1, 32'h0);
      repeat (2) @(posedge clk_sys);
      check("pins released", {16'h0, hp.oe, lp.oe}, 32'h0);
      results();
   end
endmodule : tb_bmio_top
bind bmio_top bmio_top_monitor i_mon (.clk_sys(clk_sys), .arst_n(arst_n),
   .hreadyout(hreadyout), .hresp(hresp), .low_bus_port_pins(low_bus_port_pins),
   .high_bus_port_pins(high_bus_port_pins), .ctrl_port_pins(ctrl_port_pins));
